// *** hw/power_button_state_sequencer.sv ***
// power button supervisor and orderly shutdown sequencer
`timescale 1ns/1ns
`include "pbs_params.svh"

module power_button_state_sequencer
    import pbs_pkg::*;
#(
    parameter int DEB_CYC      = (`PBS_DEBOUNCE_US * (`PBS_CLK_HZ / `PBS_US_PER_S)),
    parameter int HOLD_CYC     = (`PBS_HOLD_S * `PBS_CLK_HZ),
    parameter int SUPPRESS_CYC = (`PBS_SUPPRESS_S * `PBS_CLK_HZ)
) (
    // clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         sys_rst_i,
    // button and sensor pins
    input  wire logic         front_btn_i,
    input  wire logic         remote_button_input_i,
    input  wire logic         overtemp_i,
    // host status
    input  wire host_status_t host_status_i,
    // control outputs
    output seq_ctrl_t         ctrl_o
);

    localparam int CW = `PBS_CNT_W;

    // ****************************************
    // elaboration checks
    // ****************************************
    // counters are CW bits wide and never count past their set value; bigger settings cannot be served
    if (DEB_CYC < 1 || DEB_CYC >= (2 ** CW)) begin : g_bad_deb
        $error("debounce count out of range");
    end
    if (HOLD_CYC < 2 || HOLD_CYC >= (2 ** CW)) begin : g_bad_hold
        $error("hold count out of range");
    end
    if (SUPPRESS_CYC < 1 || SUPPRESS_CYC >= (2 ** CW)) begin : g_bad_supp
        $error("suppress count out of range");
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [`PBS_NUM_BTN-1:0] btn_raw;
    logic [`PBS_NUM_BTN-1:0] btn_m_r;
    logic [`PBS_NUM_BTN-1:0] btn_s_r;
    logic                    ot_m_r;
    logic                    ot_s_r;

    assign btn_raw = {remote_button_input_i, front_btn_i};

    // two stages per pin; first stage feeds only the second
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            btn_m_r <= '0;
            btn_s_r <= '0;
            ot_m_r  <= 1'b0;
            ot_s_r  <= 1'b0;
        end else begin
            btn_m_r <= btn_raw;
            btn_s_r <= btn_m_r;
            ot_m_r  <= overtemp_i;
            ot_s_r  <= ot_m_r;
        end
    end

    // ****************************************
    // debounce, one filter per button
    // ****************************************
    logic [`PBS_NUM_BTN-1:0] deb_r;

    genvar gi;
    generate
        for (gi = 0; gi < `PBS_NUM_BTN; gi++) begin : g_deb
            logic [CW-1:0] cnt_r;
            logic [CW-1:0] cnt_nxt;
            logic          lvl_r;
            logic          lvl_nxt;

            assign deb_r[gi] = lvl_r; // one driver per bit of the shared vector

            // level only moves after the pin held its new value DEB_CYC cycles
            always_comb begin
                cnt_nxt = '0;
                lvl_nxt = lvl_r;
                if (btn_s_r[gi] != lvl_r) begin
                    if (cnt_r == CW'(DEB_CYC - 1)) begin
                        lvl_nxt = btn_s_r[gi];
                    end else begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
            end

            always_ff @(posedge clk_sys_i) begin
                if (sys_rst_i) begin
                    cnt_r     <= '0;
                    lvl_r     <= 1'b0;
                end else begin
                    cnt_r     <= cnt_nxt;
                    lvl_r     <= lvl_nxt;
                end
            end
        end
    endgenerate

    // ****************************************
    // press duration measurement
    // ****************************************
    logic          pressed;
    logic          pressed_d_r;
    logic [CW-1:0] held_r;
    logic [CW-1:0] held_nxt;
    logic          long_done_r;
    logic          long_done_nxt;
    logic          brief_r;
    logic          brief_nxt;
    logic          long_r;
    logic          long_nxt;

    // either button counts; both pressed at once is one press
    assign pressed = |deb_r;

    // brief fires on release before the hold time, long fires once at it
    always_comb begin
        held_nxt      = '0;
        long_done_nxt = long_done_r;
        brief_nxt     = 1'b0;
        long_nxt      = 1'b0;
        if (pressed) begin
            if (!long_done_r) begin
                held_nxt = held_r + 1'b1;
                if (held_r == CW'(HOLD_CYC - 1)) begin
                    long_nxt      = 1'b1;
                    long_done_nxt = 1'b1;
                end
            end
        end else begin
            long_done_nxt = 1'b0;
            // release after a long hold is not a brief press
            if (pressed_d_r && !long_done_r) begin
                brief_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pressed_d_r <= 1'b0;
            held_r      <= '0;
            long_done_r <= 1'b0;
            brief_r     <= 1'b0;
            long_r      <= 1'b0;
        end else begin
            pressed_d_r <= pressed;
            held_r      <= held_nxt;
            long_done_r <= long_done_nxt;
            brief_r     <= brief_nxt;
            long_r      <= long_nxt;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    seq_state_t    state_r;
    seq_state_t    state_nxt;
    seq_ctrl_t     ctrl_r;
    seq_ctrl_t     ctrl_nxt;
    logic [CW-1:0] supp_r;
    logic [CW-1:0] supp_nxt;
    logic [1:0]    beeps_r;
    logic [1:0]    beeps_nxt;
    logic          restore_pend_r;
    logic          restore_pend_nxt;
    logic          ot_lock_r;
    logic          ot_lock_nxt;
    logic          wake_ok;
    logic          confirmed;

    assign wake_ok   = host_status_i.wake_req && (supp_r == '0);
    assign confirmed = host_status_i.meas_running && (beeps_r == `PBS_BEEPS_NEEDED);

    always_comb begin
        state_nxt        = state_r;
        ctrl_nxt         = ctrl_r;
        supp_nxt         = (supp_r != '0) ? supp_r - 1'b1 : supp_r;
        beeps_nxt        = beeps_r;
        restore_pend_nxt = restore_pend_r;
        ot_lock_nxt      = ot_lock_r;
        // single-cycle strobes
        ctrl_nxt.meas_cancel  = 1'b0;
        ctrl_nxt.restore      = 1'b0;
        ctrl_nxt.overtemp_evt = 1'b0;

        // beeps count only while a measurement runs in the on state
        if (state_r != ST_ON || !host_status_i.meas_running) begin
            beeps_nxt = '0;
        end else if (host_status_i.beep && beeps_r != `PBS_BEEPS_NEEDED) begin
            beeps_nxt = beeps_r + 1'b1;
        end

        // a failed save during switch-off marks the file and goes on
        if (host_status_i.save_err && state_r != ST_OFF && state_r != ST_ON) begin
            ctrl_nxt.error_indicator = 1'b1;
            restore_pend_nxt         = 1'b1;
        end

        case (state_r)
            ST_OFF: begin
                // lock lifts only when the sensor reads normal again
                if (!ot_s_r) begin
                    ot_lock_nxt = 1'b0;
                end
                if (!ot_lock_r && !ot_s_r && (brief_r || wake_ok)) begin
                    state_nxt                = ST_ON;
                    ctrl_nxt.power_en        = 1'b1;
                    ctrl_nxt.on_led          = 1'b1;
                    ctrl_nxt.error_indicator = 1'b0;
                    ctrl_nxt.restore         = restore_pend_r;
                    restore_pend_nxt         = 1'b0;
                    if (brief_r) begin
                        supp_nxt = CW'(SUPPRESS_CYC);
                    end
                end
            end
            ST_ON: begin
                // press acts at once, no state-change delay in this path
                if (brief_r && confirmed) begin
                    ctrl_nxt.meas_cancel = 1'b1;
                end else if (brief_r) begin
                    state_nxt          = ST_STOP_MEAS;
                    ctrl_nxt.stop_meas = 1'b1;
                    ctrl_nxt.on_led    = 1'b0;
                    supp_nxt           = CW'(SUPPRESS_CYC);
                end else if (host_status_i.shutdown_req) begin
                    state_nxt          = ST_STOP_MEAS;
                    ctrl_nxt.stop_meas = 1'b1;
                    ctrl_nxt.on_led    = 1'b0;
                end
            end
            ST_STOP_MEAS: begin
                // step one: wait for the measurement to stop
                if (!host_status_i.meas_running) begin
                    state_nxt = ST_WAIT_REC;
                end
            end
            ST_WAIT_REC: begin
                // step two: recording flushed
                if (!host_status_i.rec_busy) begin
                    state_nxt = ST_WAIT_XFER;
                end
            end
            ST_WAIT_XFER: begin
                // step three: port transfer finished
                if (!host_status_i.xfer_busy) begin
                    state_nxt         = ST_PWR_DOWN;
                    ctrl_nxt.power_en = 1'b0;
                end
            end
            ST_PWR_DOWN: begin
                state_nxt          = ST_OFF;
                ctrl_nxt.stop_meas = 1'b0;
            end
            default: begin
                state_nxt = ST_OFF;
            end
        endcase

        // overtemperature cuts power like a supply loss, before anything else
        if (ot_s_r && state_r != ST_OFF) begin
            state_nxt             = ST_OFF;
            ctrl_nxt.power_en     = 1'b0;
            ctrl_nxt.on_led       = 1'b0;
            ctrl_nxt.stop_meas    = 1'b0;
            ctrl_nxt.meas_cancel  = 1'b0;
            ctrl_nxt.overtemp_evt = 1'b1;
            ot_lock_nxt           = 1'b1;
            restore_pend_nxt      = 1'b1;
        end else if (long_r && state_r != ST_OFF) begin
            // hard shutdown: nothing is waited for, data may be partial
            state_nxt            = ST_OFF;
            ctrl_nxt.power_en    = 1'b0;
            ctrl_nxt.on_led      = 1'b0;
            ctrl_nxt.stop_meas   = 1'b0;
            ctrl_nxt.meas_cancel = 1'b0;
            restore_pend_nxt     = 1'b1;
        end

        // suppression of other wake triggers is visible for the host event logic
        ctrl_nxt.wake_suppressed = (supp_nxt != '0);
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_r        <= ST_OFF;
            ctrl_r         <= '0;
            supp_r         <= '0;
            beeps_r        <= '0;
            restore_pend_r <= 1'b0;
            ot_lock_r      <= 1'b0;
        end else begin
            state_r        <= state_nxt;
            ctrl_r         <= ctrl_nxt;
            supp_r         <= supp_nxt;
            beeps_r        <= beeps_nxt;
            restore_pend_r <= restore_pend_nxt;
            ot_lock_r      <= ot_lock_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // every field comes straight from ctrl_r
    assign ctrl_o = ctrl_r;

endmodule

// *** hw/pbs_params.svh ***
// timing and count constants for the power button sequencer
`ifndef PBS_PARAMS_SVH
`define PBS_PARAMS_SVH

// ****************************************
// clock and times
// ****************************************
`define PBS_CLK_HZ       10000000
`define PBS_SUPPRESS_S   15
`define PBS_HOLD_S       5
`define PBS_DEBOUNCE_US  10000
`define PBS_US_PER_S     1000000

// ****************************************
// counts and widths
// ****************************************
`define PBS_BEEPS_NEEDED 2'h2
`define PBS_CNT_W        28
`define PBS_SYNC_W       2
`define PBS_NUM_BTN      2

`endif

// *** hw/pbs_pkg.sv ***
// types shared by the power button sequencer
package pbs_pkg;

    // ****************************************
    // sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        ST_OFF,
        ST_ON,
        ST_STOP_MEAS,
        ST_WAIT_REC,
        ST_WAIT_XFER,
        ST_PWR_DOWN
    } seq_state_t;

    // ****************************************
    // status from the embedded host logic
    // ****************************************
    typedef struct packed {
        logic meas_running;
        logic rec_busy;
        logic xfer_busy;
        logic save_err;
        logic beep;
        logic wake_req;
        logic shutdown_req;
    } host_status_t;

    // ****************************************
    // control lines to the module
    // ****************************************
    typedef struct packed {
        logic power_en;
        logic on_led;
        logic stop_meas;
        logic meas_cancel;
        logic restore;
        logic error_indicator;
        logic overtemp_evt;
        logic wake_suppressed;
    } seq_ctrl_t;

endpackage

// *** tb/pbs_props.sv ***
// checker for the power button sequencer
`timescale 1ns/1ns

module pbs_props
    import pbs_pkg::*;
(
    // clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         sys_rst_i,
    // pins and host status
    input  wire logic         front_btn_i,
    input  wire logic         remote_button_input_i,
    input  wire logic         overtemp_i,
    input  wire host_status_t host_status_i,
    // control outputs
    input  wire seq_ctrl_t    ctrl_o
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    off_start_a: assert property ($rose(ctrl_o.stop_meas) |-> ctrl_o.power_en && !ctrl_o.on_led)
        else $error("switch-off began without power or with led lit");
    off_order_a: assert property ($fell(ctrl_o.power_en) && ctrl_o.stop_meas |->
        !$past(host_status_i.xfer_busy)) else $error("power cut while transfer active");
    cancel_pulse_a: assert property (ctrl_o.meas_cancel |-> ctrl_o.on_led ##1 !ctrl_o.meas_cancel)
        else $error("cancel pulse wrong");
    hot_off_a: assert property (ctrl_o.overtemp_evt |->
        !ctrl_o.power_en && !ctrl_o.on_led && !ctrl_o.stop_meas) else $error("hot event kept power");
    // two cycles of sync lag plus one to act, so five samples leave margin
    hot_hold_a: assert property (overtemp_i [*5] |-> !ctrl_o.power_en)
        else $error("powered while hot");
    restore_on_a: assert property (ctrl_o.restore |-> ctrl_o.power_en)
        else $error("restore while unpowered");
    err_set_a: assert property (ctrl_o.stop_meas && ctrl_o.power_en && host_status_i.save_err
        |=> ctrl_o.error_indicator) else $error("save failure not shown");
    err_clear_a: assert property ($rose(ctrl_o.power_en) |-> !ctrl_o.error_indicator)
        else $error("error indicator kept over power-on");

    // main scenarios reached
    cover property ($rose(ctrl_o.power_en));
    cover property (ctrl_o.meas_cancel);
    cover property (ctrl_o.overtemp_evt);
endmodule

bind power_button_state_sequencer pbs_props u_props (
    .clk_sys_i             (clk_sys_i),
    .sys_rst_i             (sys_rst_i),
    .front_btn_i           (front_btn_i),
    .remote_button_input_i (remote_button_input_i),
    .overtemp_i            (overtemp_i),
    .host_status_i         (host_status_i),
    .ctrl_o                (ctrl_o)
);

// *** tb/pbs_button_model.sv ***
// operator buttons driving the sequencer pins
`timescale 1ns/1ns

module pbs_button_model (
    // clock
    input  wire logic clk_sys_i,
    // button pins
    output wire logic front_o,
    output wire logic remote_o
);
    // ****************************************
    // contacts
    // ****************************************
    logic [1:0] pins_r = 2'h0;

    // released contacts rest low; presses come only on request, never during updates
    assign front_o  = pins_r[0];
    assign remote_o = pins_r[1];

    // chatter of one-cycle pulses, then a clean hold and release
    task automatic press(input bit rmt, input int cyc, input int chatter);
        for (int i = 0; i < chatter + cyc; i++) begin
            @(posedge clk_sys_i);
            pins_r[rmt] <= (i >= chatter) || (i % 2 == 0);
        end
        @(posedge clk_sys_i);
        pins_r[rmt] <= 1'h0;
        // return off the edge so callers never read outputs still settling
        #1;
    endtask
endmodule

// *** tb/power_button_state_sequencer_tb.sv ***
// self-checking bench for the power button sequencer
`timescale 1ns/1ns

module power_button_state_sequencer_tb;
    import pbs_pkg::*;
    // ****************************************
    // setup
    // ****************************************
    localparam int DEB = 4;
    localparam int HOLD = 40;
    localparam int SUP = 30;
    localparam int PWR = 7;
    localparam int LED = 6;
    localparam int STP = 5;
    localparam int CAN = 4;
    localparam int RST = 3;
    localparam int ERR = 2;
    localparam int HOT = 1;
    localparam int SUPW = 0;
    logic         clk_sys_i;
    logic         sys_rst_i;
    logic         overtemp_i;
    logic         front;
    logic         remote;
    host_status_t hs;
    seq_ctrl_t    ctrl;
    int           num_errors = 0;
    int           comparisons = 0;
    int           cycles = 0;

    pbs_button_model bm (.clk_sys_i(clk_sys_i), .front_o(front), .remote_o(remote));
    power_button_state_sequencer #(.DEB_CYC(DEB), .HOLD_CYC(HOLD), .SUPPRESS_CYC(SUP)) DUT (
        .clk_sys_i             (clk_sys_i),
        .sys_rst_i             (sys_rst_i),
        .front_btn_i           (front),
        .remote_button_input_i (remote),
        .overtemp_i            (overtemp_i),
        .host_status_i         (hs),
        .ctrl_o                (ctrl)
    );

    // clock
    initial begin
        clk_sys_i = 1'h0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic chk(input string nm, input logic ex, input logic got);
        comparisons++;
        if (got !== ex) begin
            num_errors++;
            $display("BAD %s expected %b seen %b", nm, ex, got);
        end
    endtask
    // bounded wait on one control bit; a limit of 0 is a plain check
    task automatic want(input string nm, input int idx, input logic v, input int lim);
        for (int i = 0; i < lim && ctrl[idx] !== v; i++) tick(1);
        chk(nm, v, ctrl[idx]);
    endtask
    task automatic set_hs(input logic [6:0] v);
        @(posedge clk_sys_i);
        hs <= host_status_t'(v);
        #1;
    endtask
    task automatic test_done;
        if (num_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_power_on;
        int n;
        n = 0;
        bm.press(0, 0, 3);
        tick(20);
        want("glitch_off", PWR, 1'h0, 0);
        bm.press(1, 10, 5);
        want("power_en", PWR, 1'h1, 40);
        want("on_led", LED, 1'h1, 0);
        while (ctrl[SUPW] === 1'h1 && n < SUP + 10) begin
            tick(1);
            n++;
        end
        chk("suppress_len", 1'h1, n == SUP);
    endtask
    task automatic t_power_off;
        set_hs(7'h70);
        bm.press(0, 10, 0);
        want("stop_meas", STP, 1'h1, DEB + 5);
        want("on_led_off", LED, 1'h0, 0);
        want("suppress", SUPW, 1'h1, 0);
        tick(2);
        set_hs(7'h30);
        tick(2);
        want("hold_rec", PWR, 1'h1, 0);
        set_hs(7'h10);
        tick(2);
        want("hold_xfer", PWR, 1'h1, 0);
        set_hs(7'h00);
        want("power_down", PWR, 1'h0, 4);
        set_hs(7'h02);
        tick(2);
        want("wake_blocked", PWR, 1'h0, 0);
        want("suppress_end", SUPW, 1'h0, SUP);
        want("wake_taken", PWR, 1'h1, 5);
        set_hs(7'h00);
    endtask
    task automatic t_cancel;
        set_hs(7'h40);
        repeat (2) begin
            set_hs(7'h44);
            set_hs(7'h40);
        end
        bm.press(1, 10, 0);
        want("cancel", CAN, 1'h1, 40);
        tick(1);
        want("cancel_end", CAN, 1'h0, 0);
        want("stay_on", PWR, 1'h1, 0);
        want("no_stop", STP, 1'h0, 0);
        set_hs(7'h00);
    endtask
    task automatic t_save_err;
        set_hs(7'h21);
        want("stop_meas", STP, 1'h1, 3);
        want("no_supp", SUPW, 1'h0, 0);
        set_hs(7'h28);
        set_hs(7'h20);
        want("err_lit", ERR, 1'h1, 0);
        want("goes_on", STP, 1'h1, 0);
        set_hs(7'h00);
        want("power_down", PWR, 1'h0, 10);
        bm.press(0, 10, 0);
        want("restore", RST, 1'h1, 40);
        want("err_clear", ERR, 1'h0, 0);
    endtask
    task automatic t_long;
        set_hs(7'h40);
        fork
            bm.press(0, HOLD + 30, 0);
        join_none
        want("hard_off", PWR, 1'h0, HOLD + 15);
        chk("held", 1'h1, front);
        want("no_order", STP, 1'h0, 0);
        tick(40);
        want("stay_off", PWR, 1'h0, 0);
        set_hs(7'h00);
    endtask
    task automatic t_overtemp;
        bm.press(0, 10, 0);
        want("power_en", PWR, 1'h1, 40);
        @(posedge clk_sys_i);
        overtemp_i <= 1'h1;
        want("hot_evt", HOT, 1'h1, 6);
        want("hot_off", PWR, 1'h0, 0);
        bm.press(0, 10, 0);
        tick(10);
        want("hot_lock", PWR, 1'h0, 0);
        @(posedge clk_sys_i);
        overtemp_i <= 1'h0;
        tick(3);
        bm.press(0, 10, 0);
        want("restore", RST, 1'h1, 40);
        want("restart", PWR, 1'h1, 0);
    endtask

    // ****************************************
    // main sequence and hang guard
    // ****************************************
    initial begin
        sys_rst_i = 1'h1;
        overtemp_i = 1'h0;
        hs = host_status_t'(7'h00);
        repeat (20) @(posedge clk_sys_i);
        sys_rst_i <= 1'h0;
        tick(2);
        t_power_on();
        t_power_off();
        t_cancel();
        t_save_err();
        t_long();
        t_overtemp();
        test_done();
    end
    // the whole run needs well under two thousand cycles
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            num_errors++;
            test_done();
        end
    end
endmodule
